//--- logic/dma_channel_event_control.sv
`timescale 1ns/10ps
module dma_channel_event_control
  import dma_event_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // AXI4-Lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Interrupt request lines and engine events
  input  wire logic [IRQ_COUNT-1:0] irq_req,
  input  wire logic                 pattern_match,
  // Engine commands and interrupt
  output engine_cmd_t               cmd,
  output logic                      channel_enable,
  output logic                      irq
);
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic [7:0]  rd_addr;
  logic [7:0]  next_aw_addr;
  logic        next_aw_held;
  logic        next_awready;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_w_held;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [7:0]  next_rd_addr;
  logic        do_write;
  logic        ar_fire;
  logic        mapped_wr;
  logic        mapped_rd;

  econ_t       econ;
  econ_t       next_econ;
  engine_cmd_t next_cmd;
  logic        next_channel_enable;
  logic        force_wr;
  logic        abort_wr;
  logic        pat_abort;
  logic        start_hit;
  logic        abort_hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic        mask_wr;

  // Write channel: address and data taken in either order
  always_comb begin
    do_write     = aw_held && w_held && !bvalid;
    next_aw_addr = (awvalid && awready) ? awaddr : aw_addr;
    next_aw_held = do_write ? 1'b0 : (aw_held || (awvalid && awready));
    next_awready = !next_aw_held;
    next_w_data  = (wvalid && wready) ? wdata : w_data;
    next_w_strb  = (wvalid && wready) ? wstrb : w_strb;
    next_w_held  = do_write ? 1'b0 : (w_held || (wvalid && wready));
    next_wready  = !next_w_held;
    mapped_wr    = (aw_addr == ECON_ADDR) || (aw_addr == STATUS_ADDR) ||
                   (aw_addr == MASK_ADDR) || (aw_addr == CTRL_ADDR);
    next_bvalid  = do_write || (bvalid && !bready);
    next_bresp   = do_write ? (mapped_wr ? RESP_OKAY : RESP_SLVERR) : bresp;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_addr <= '0;
      aw_held <= 1'b0;
      awready <= 1'b1;
      w_data  <= '0;
      w_strb  <= '0;
      w_held  <= 1'b0;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      awready <= next_awready;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      w_held  <= next_w_held;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // Read channel: one read at a time, data from a register
  always_comb begin
    ar_fire      = arvalid && arready;
    next_rvalid  = ar_fire || (rvalid && !rready);
    next_arready = !next_rvalid;
    next_rd_addr = ar_fire ? araddr : rd_addr;
    mapped_rd    = 1'b1;
    next_rdata   = '0;
    unique case (araddr)
      ECON_ADDR: begin
        next_rdata[ABORT_NUM_LSB +: 8] = econ.abort_irq_number;
        next_rdata[START_NUM_LSB +: 8] = econ.start_irq_number;
        next_rdata[PATTERN_ABORT_ENABLE_BIT]          = econ.pattern_abort_enable;
        next_rdata[START_IRQ_ENABLE_BIT]         = econ.start_irq_enable;
        next_rdata[ABORT_IRQ_ENABLE_BIT]         = econ.abort_irq_enable;
      end
      STATUS_ADDR: next_rdata[EV_W-1:0] = status;
      MASK_ADDR:   next_rdata[EV_W-1:0] = mask;
      CTRL_ADDR:   next_rdata[CHANNEL_ENABLE_BIT] = channel_enable;
      default:     mapped_rd = 1'b0;
    endcase
    if (!ar_fire) begin
      next_rdata = rdata;
    end
    next_rresp = ar_fire ? (mapped_rd ? RESP_OKAY : RESP_SLVERR) : rresp;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      rd_addr <= '0;
    end else begin
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      rd_addr <= next_rd_addr;
    end
  end

  irq_number_match u_start_match (
    .clk     (clk),
    .rst     (rst),
    .irq_req (irq_req),
    .number  (econ.start_irq_number),
    .enable  (econ.start_irq_enable),
    .hit     (start_hit)
  );

  irq_number_match u_abort_match (
    .clk     (clk),
    .rst     (rst),
    .irq_req (irq_req),
    .number  (econ.abort_irq_number),
    .enable  (econ.abort_irq_enable),
    .hit     (abort_hit)
  );

  // Event control register and commands
  always_comb begin
    next_econ = econ;
    force_wr  = 1'b0;
    abort_wr  = 1'b0;
    mask_wr   = 1'b0;
    ev_clr    = '0;
    if (do_write && aw_addr == ECON_ADDR) begin
      if (w_strb[2]) begin
        next_econ.abort_irq_number = w_data[ABORT_NUM_LSB +: 8];
      end
      if (w_strb[1]) begin
        next_econ.start_irq_number = w_data[START_NUM_LSB +: 8];
      end
      if (w_strb[0]) begin
        force_wr = w_data[FORCE_BIT];
        abort_wr = w_data[ABORT_BIT];
        next_econ.pattern_abort_enable = w_data[PATTERN_ABORT_ENABLE_BIT];
        next_econ.start_irq_enable     = w_data[START_IRQ_ENABLE_BIT];
        next_econ.abort_irq_enable     = w_data[ABORT_IRQ_ENABLE_BIT];
      end
    end
    if (do_write && aw_addr == STATUS_ADDR && w_strb[0]) begin
      ev_clr = w_data[EV_W-1:0];
    end
    if (do_write && aw_addr == MASK_ADDR && w_strb[0]) begin
      mask_wr = 1'b1;
    end
    pat_abort = econ.pattern_abort_enable && pattern_match;
    next_channel_enable = channel_enable;
    if (do_write && aw_addr == CTRL_ADDR && w_strb[0]) begin
      next_channel_enable = w_data[CHANNEL_ENABLE_BIT];
    end
    if (pat_abort) begin
      next_channel_enable = 1'b0;
    end
    next_cmd.start        = force_wr || start_hit;
    next_cmd.abort        = abort_wr || abort_hit || pat_abort;
    next_cmd.clear_enable = pat_abort;
    ev_set               = '0;
    ev_set[EV_IRQ_ABORT] = abort_hit;
    ev_set[EV_PAT_ABORT] = pat_abort;
    ev_set[EV_SW_ABORT]  = abort_wr;
    ev_set[EV_START]     = next_cmd.start;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      econ.abort_irq_number     <= IRQ_NUM_RESET;
      econ.start_irq_number     <= IRQ_NUM_RESET;
      econ.pattern_abort_enable <= 1'b0;
      econ.start_irq_enable     <= 1'b0;
      econ.abort_irq_enable     <= 1'b0;
      cmd                       <= '0;
      channel_enable            <= 1'b0;
    end else begin
      econ           <= next_econ;
      cmd            <= next_cmd;
      channel_enable <= next_channel_enable;
    end
  end

  event_flags u_flags (
    .clk       (clk),
    .rst       (rst),
    .set       (ev_set),
    .clr       (ev_clr),
    .mask_wr   (mask_wr),
    .mask_data (w_data[EV_W-1:0]),
    .status    (status),
    .mask      (mask),
    .irq       (irq)
  );

  property p_force_start;
    @(posedge clk) disable iff (rst)
    (do_write && aw_addr == ECON_ADDR && w_strb[0] && w_data[FORCE_BIT]) |=> cmd.start;
  endproperty
  a_force_start: assert property (p_force_start)
    else $error("force write did not start a transfer");

  property p_abort_field;
    @(posedge clk) disable iff (rst)
    (do_write && aw_addr == ECON_ADDR && w_strb[2])
      |=> econ.abort_irq_number == $past(w_data[ABORT_NUM_LSB +: 8]);
  endproperty
  a_abort_field: assert property (p_abort_field)
    else $error("abort number not taken from its field");

  property p_sw_abort;
    @(posedge clk) disable iff (rst)
    (do_write && aw_addr == ECON_ADDR && w_strb[0] && w_data[ABORT_BIT])
      |=> cmd.abort ##1 status[EV_SW_ABORT];
  endproperty
  a_sw_abort: assert property (p_sw_abort)
    else $error("abort write did not abort");

  property p_pat_abort;
    @(posedge clk) disable iff (rst)
    (pattern_match && econ.pattern_abort_enable)
      |=> cmd.abort && cmd.clear_enable && !channel_enable;
  endproperty
  a_pat_abort: assert property (p_pat_abort)
    else $error("pattern match did not abort and clear enable");

  property p_pat_off;
    @(posedge clk) disable iff (rst)
    !(pattern_match && econ.pattern_abort_enable) |=> !cmd.clear_enable;
  endproperty
  a_pat_off: assert property (p_pat_off)
    else $error("enable cleared without pattern abort");

  property p_start_irq;
    @(posedge clk) disable iff (rst)
    (econ.start_irq_enable && irq_req[econ.start_irq_number] &&
     !$past(irq_req[econ.start_irq_number]) && $stable(econ)) |=> ##1 cmd.start;
  endproperty
  a_start_irq: assert property (p_start_irq)
    else $error("selected start interrupt did not start");

  property p_start_cause;
    @(posedge clk) disable iff (rst)
    cmd.start |-> $past(force_wr) || ($past(start_hit) && $past(econ.start_irq_enable, 2));
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without force or enabled interrupt");

  property p_abort_irq;
    @(posedge clk) disable iff (rst)
    abort_hit |=> cmd.abort && status[EV_IRQ_ABORT];
  endproperty
  a_abort_irq: assert property (p_abort_irq)
    else $error("abort interrupt did not abort and set flag");

  property p_abort_off;
    @(posedge clk) disable iff (rst)
    (!econ.abort_irq_enable && $stable(econ.abort_irq_enable)) |=> !abort_hit;
  endproperty
  a_abort_off: assert property (p_abort_off)
    else $error("disabled abort interrupt still hit");

  property p_reserved_read;
    @(posedge clk) disable iff (rst)
    (rvalid && rd_addr == ECON_ADDR) |-> rdata[31:24] == 8'h00 && rdata[7:6] == 2'h0 &&
      rdata[2:0] == 3'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("unused event control bits read nonzero");

  property p_reset_value;
    @(posedge clk) $fell(rst) |-> econ.abort_irq_number == IRQ_NUM_RESET &&
      econ.start_irq_number == IRQ_NUM_RESET && !econ.start_irq_enable &&
      !econ.pattern_abort_enable && !econ.abort_irq_enable;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("wrong event control value after reset");

  property p_resp_hold;
    @(posedge clk) disable iff (rst)
    (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_resp_hold: assert property (p_resp_hold)
    else $error("write response dropped before taken");
endmodule

//--- logic/dma_event_pkg.sv
package dma_event_pkg;

  // Register byte addresses
  localparam logic [7:0] ECON_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR   = 8'h08;
  localparam logic [7:0] CTRL_ADDR   = 8'h0c;

  // Event control field positions, and the channel enable bit of the control register
  localparam int ABORT_NUM_LSB = 16;
  localparam int START_NUM_LSB = 8;
  localparam int FORCE_BIT     = 7;
  localparam int ABORT_BIT     = 6;
  localparam int PATTERN_ABORT_ENABLE_BIT     = 5;
  localparam int START_IRQ_ENABLE_BIT    = 4;
  localparam int ABORT_IRQ_ENABLE_BIT    = 3;
  localparam int CHANNEL_ENABLE_BIT      = 0;

  localparam int            IRQ_COUNT     = 256;
  localparam logic [7:0]    IRQ_NUM_RESET = 8'hff;

  // Status and mask bit positions
  localparam int EV_W         = 4;
  localparam int EV_IRQ_ABORT = 0;
  localparam int EV_PAT_ABORT = 1;
  localparam int EV_SW_ABORT  = 2;
  localparam int EV_START     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] abort_irq_number;
    logic [7:0] start_irq_number;
    logic       pattern_abort_enable;
    logic       start_irq_enable;
    logic       abort_irq_enable;
  } econ_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic clear_enable;
  } engine_cmd_t;

endpackage

//--- logic/irq_number_match.sv
`timescale 1ns/10ps
module irq_number_match
  import dma_event_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Request lines and selection
  input  wire logic [IRQ_COUNT-1:0] irq_req,
  input  wire logic [7:0]           number,
  input  wire logic                 enable,
  // One-cycle hit
  output logic                      hit
);
  logic [IRQ_COUNT-1:0] prev;
  logic                 next_hit;

  // Rising edge of the selected line only
  always_comb begin
    next_hit = enable && irq_req[number] && !prev[number];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
      hit  <= 1'b0;
    end else begin
      prev <= irq_req;
      hit  <= next_hit;
    end
  end
endmodule

//--- logic/event_flags.sv
`timescale 1ns/10ps
module event_flags
  import dma_event_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Hardware events and software access
  input  wire logic [EV_W-1:0] set,
  input  wire logic [EV_W-1:0] clr,
  input  wire logic            mask_wr,
  input  wire logic [EV_W-1:0] mask_data,
  // State
  output logic      [EV_W-1:0] status,
  output logic      [EV_W-1:0] mask,
  output logic                 irq
);
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] next_mask;
  logic            next_irq;

  // Set wins over a same-cycle clear
  always_comb begin
    next_status = (status & ~clr) | set;
    next_mask   = mask_wr ? mask_data : mask;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end
endmodule

//--- tb/xfer_engine_model.sv
`timescale 1ns/10ps
module xfer_engine_model
  import dma_event_pkg::*;
(
  // Clock and engine commands
  input  wire logic                 clk,
  input  wire engine_cmd_t          cmd,
  // Request lines and pattern event
  output logic [IRQ_COUNT-1:0]      irq_req,
  output logic                      pattern_match
);
  int n_start = 0;
  int n_abort = 0;
  int n_clear = 0;

  initial begin
    irq_req = '0;
    pattern_match = 1'b0;
  end

  // Engine counts each command pulse it receives
  always @(posedge clk) begin
    n_start += int'(cmd.start);
    n_abort += int'(cmd.abort);
    n_clear += int'(cmd.clear_enable);
  end

  // A line must fall again before its next rise counts
  task automatic raise_irq(input int n);
    @(posedge clk);
    irq_req[n] <= 1'b1;
    @(posedge clk);
    irq_req[n] <= 1'b0;
  endtask

  task automatic pulse_pattern();
    @(posedge clk);
    pattern_match <= 1'b1;
    @(posedge clk);
    pattern_match <= 1'b0;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dma_event_pkg::*;
  logic                 clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid, channel_enable, irq;
  logic                 pattern_match;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  logic [IRQ_COUNT-1:0] irq_req;
  engine_cmd_t          cmd;
  logic [7:0]           nums [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  int                   failures = 0;
  int                   n_checks = 0;

  dma_channel_event_control dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq_req, .pattern_match, .cmd, .channel_enable, .irq);

  xfer_engine_model m (.clk, .cmd, .irq_req, .pattern_match);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic       aw, w, b;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // Response must drop once taken
    @(negedge clk);
    chk("bvalid", {31'h0, bvalid}, 32'h0);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic        ah, v;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge clk);
      ah = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(negedge clk);
    chk("rvalid", {31'h0, rvalid}, 32'h0);
    chk("rdata", d, ex);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // Engine commands counted since the last look
  task automatic ev(input string nm, input logic [7:0] s, input logic [7:0] a,
                    input logic [7:0] c);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(nm, {8'h0, m.n_start[7:0], m.n_abort[7:0], m.n_clear[7:0]}, {8'h0, s, a, c});
    m.n_start = 0;
    m.n_abort = 0;
    m.n_clear = 0;
  endtask

  task automatic lvl(input string nm, input logic [1:0] e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(nm, {30'h0, irq, channel_enable}, {30'h0, e});
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ECON_ADDR, 32'h00ffff00, RESP_OKAY);
    lvl("idle outputs", 2'b00);
    wr(ECON_ADDR, 32'hffffffff, 4'hf, RESP_OKAY);
    ev("strobes", 8'h1, 8'h1, 8'h0);
    rd_reg(ECON_ADDR, 32'h00ffff38, RESP_OKAY);
    wr(STATUS_ADDR, 32'h0000000f, 4'hf, RESP_OKAY);
    // line 255 both starts and aborts
    m.raise_irq(255);
    ev("irq 255", 8'h1, 8'h1, 8'h0);
    rd_reg(STATUS_ADDR, 32'h00000009, RESP_OKAY);
    wr(MASK_ADDR, 32'h00000001, 4'hf, RESP_OKAY);
    lvl("flag irq", 2'b10);
    wr(STATUS_ADDR, 32'h00000001, 4'hf, RESP_OKAY);
    lvl("flag cleared", 2'b00);
    wr(ECON_ADDR, 32'h00ff0500, 4'hf, RESP_OKAY);
    m.raise_irq(255);
    m.raise_irq(5);
    ev("irq disabled", 8'h0, 8'h0, 8'h0);
    // start number selects its own line only
    for (int i = 0; i < 4; i++) begin
      wr(ECON_ADDR, {16'h0000, nums[i], 8'h10}, 4'hf, RESP_OKAY);
      m.raise_irq(int'(nums[i]));
      ev("start hit", 8'h1, 8'h0, 8'h0);
      m.raise_irq(int'(nums[i] ^ 8'h01));
      ev("start miss", 8'h0, 8'h0, 8'h0);
    end
    wr(STATUS_ADDR, 32'h0000000f, 4'hf, RESP_OKAY);
    wr(CTRL_ADDR, 32'h00000001, 4'hf, RESP_OKAY);
    m.pulse_pattern();
    ev("pattern off", 8'h0, 8'h0, 8'h0);
    lvl("enable kept", 2'b01);
    wr(ECON_ADDR, 32'h00000020, 4'hf, RESP_OKAY);
    m.pulse_pattern();
    ev("pattern on", 8'h0, 8'h1, 8'h1);
    lvl("enable cleared", 2'b00);
    rd_reg(STATUS_ADDR, 32'h00000002, RESP_OKAY);
    wr(ECON_ADDR, 32'h11aa5500, 4'h4, RESP_OKAY);
    rd_reg(ECON_ADDR, 32'h00aa0020, RESP_OKAY);
    wr(8'h10, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd_reg(8'h10, 32'h00000000, RESP_SLVERR);
    wr(CTRL_ADDR, 32'h00000001, 4'hf, RESP_OKAY);
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ECON_ADDR, 32'h00ffff00, RESP_OKAY);
    rd_reg(CTRL_ADDR, 32'h00000000, RESP_OKAY);
    final_report();
  end

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule
